// ### anc_window_pkg.sv
// constants, types and register map of the ancillary window register bank
// ============================================================================
`default_nettype none

package anc_window_pkg;

  // ==========================================================================
  // bus and field geometry
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = DATA_W / 8;
  localparam int FLD_W     = 11;
  localparam int LINE_LSB  = 16;
  localparam int LINE_MSB  = 26;
  localparam int BYTE_LSB  = 0;
  localparam int BYTE_MSB  = 10;
  localparam int LANE_W    = 8;
  localparam int HI_W      = FLD_W - LANE_W;
  localparam int NUM_CH    = 2;
  localparam int NUM_REG   = 6;
  localparam int IDX_W     = 3;

  // ==========================================================================
  // register map: channel 2 block, then channel 3 block
  localparam logic [ADDR_W-1:0] OFF_BH_POS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BH_SIZE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TV_POS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TV_SIZE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_BV_POS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BV_SIZE = 8'h14;
  localparam logic [ADDR_W-1:0] CH_STRIDE   = 8'h20;
  localparam int                CH_BIT      = 5;
  localparam int                IDX_LSB     = 2;
  localparam int                TOP_LSB     = 6;

  // register indices inside a channel block
  localparam logic [IDX_W-1:0] IDX_BH_POS  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_BH_SIZE = 3'h1;
  localparam logic [IDX_W-1:0] IDX_TV_POS  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_TV_SIZE = 3'h3;
  localparam logic [IDX_W-1:0] IDX_BV_POS  = 3'h4;
  localparam logic [IDX_W-1:0] IDX_BV_SIZE = 3'h5;

  localparam logic [FLD_W-1:0] FLD_RESET = 11'h000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [FLD_W-1:0] line;      // start line or line count
    logic [FLD_W-1:0] byte_pos;  // start byte or byte count
  } anc_field_t;

  typedef struct packed {
    anc_field_t pos;
    anc_field_t size;
  } anc_window_t;

  typedef struct packed {
    anc_window_t bottom_hblank;
    anc_window_t top_vblank;
    anc_window_t bottom_vblank;
  } anc_cfg_t;

  typedef struct packed {
    logic             valid;         // position below is meaningful
    logic             bottom_field;  // 1 bottom field, 0 top field
    logic             hblank;        // inside horizontal blanking
    logic             vblank;        // inside vertical blanking
    logic [FLD_W-1:0] line_num;      // line within region, first line is 1
    logic [FLD_W-1:0] byte_num;      // byte within region, first byte is 0
  } video_pos_t;

endpackage

`default_nettype wire

// ### anc_window_regs.sv
// apb register bank and ancillary window detector for video channels 2 and 3
//
// The register addresses and the APB slave port are this design's own decisions.
`default_nettype none

module ancillary_window_config_regs #(
  parameter int NCH = anc_window_pkg::NUM_CH
) (
  input  wire logic                                pclk,        // bus clock, 200 mhz
  input  wire logic                                presetn,     // async reset, low active
  input  wire logic                                psel,        // apb select
  input  wire logic                                penable,     // apb access phase
  input  wire logic                                pwrite,      // apb direction
  input  wire logic [anc_window_pkg::ADDR_W-1:0]   paddr,       // apb byte address
  input  wire logic [anc_window_pkg::DATA_W-1:0]   pwdata,      // apb write data
  input  wire logic [anc_window_pkg::STRB_W-1:0]   pstrb,       // apb byte lanes
  output logic      [anc_window_pkg::DATA_W-1:0]   prdata,      // apb read data
  output logic                                     pready,      // apb ready
  output logic                                     pslverr,     // apb error
  input  wire anc_window_pkg::video_pos_t          video_pos [NCH], // output scan position
  output anc_window_pkg::anc_cfg_t                 anc_cfg   [NCH], // programmed windows
  output logic      [NCH-1:0]                      anc_active   // byte is ancillary data
);
  import anc_window_pkg::*;

  // ==========================================================================
  // helpers

  // merge written byte lanes into one position/size field pair
  function automatic anc_field_t merge_write(input anc_field_t old_f,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [STRB_W-1:0] st);
    anc_field_t r;
    r = old_f;
    if (st[0]) begin
      r.byte_pos[LANE_W-1:0] = wd[BYTE_LSB +: LANE_W];
    end
    if (st[1]) begin
      r.byte_pos[FLD_W-1:LANE_W] = wd[BYTE_LSB+LANE_W +: HI_W];
    end
    if (st[2]) begin
      r.line[LANE_W-1:0] = wd[LINE_LSB +: LANE_W];
    end
    if (st[3]) begin
      r.line[FLD_W-1:LANE_W] = wd[LINE_LSB+LANE_W +: HI_W];
    end
    return r;
  endfunction

  // place a field pair in a bus word, gaps left at zero
  function automatic logic [DATA_W-1:0] pack_word(input anc_field_t f);
    logic [DATA_W-1:0] w;
    w = '0;
    w[LINE_MSB:LINE_LSB] = f.line;
    w[BYTE_MSB:BYTE_LSB] = f.byte_pos;
    return w;
  endfunction

  // position falls in [start, start + count)
  function automatic logic in_range(input logic [FLD_W-1:0] v,
                                    input logic [FLD_W-1:0] s,
                                    input logic [FLD_W-1:0] c);
    logic [FLD_W:0] end_x;
    end_x = {1'b0, s} + {1'b0, c};
    return (v >= s) && ({1'b0, v} < end_x);
  endfunction

  // both line and byte inside the window
  function automatic logic in_window(input video_pos_t p, input anc_window_t w);
    return in_range(p.line_num, w.pos.line, w.size.line) &&
           in_range(p.byte_num, w.pos.byte_pos, w.size.byte_pos);
  endfunction

  // ==========================================================================
  // address decode

  wire logic [IDX_W-1:0] reg_idx  = paddr[IDX_LSB +: IDX_W];
  wire logic             ch_idx   = paddr[CH_BIT];
  wire logic             aligned  = (paddr[IDX_LSB-1:0] == '0);
  wire logic             top_zero = (paddr[ADDR_W-1:TOP_LSB] == '0);
  wire logic             idx_ok   = (reg_idx <= IDX_BV_SIZE);
  wire logic             mapped   = aligned && top_zero && idx_ok;
  wire logic             setup    = psel && !penable;
  wire logic             access_p = psel && penable;
  wire logic             wr_hit   = access_p && pwrite && mapped;

  // ==========================================================================
  // storage: every channel keeps its own six field pairs

  anc_field_t win_ff [NCH][NUM_REG];

  // read word of the addressed register
  wire anc_field_t rd_field = win_ff[ch_idx][reg_idx];
  wire logic [DATA_W-1:0] rd_word = pack_word(rd_field);

  // only the two fields store, gaps stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        for (int r = 0; r < NUM_REG; r++) begin
          win_ff[c][r] <= '{line: FLD_RESET, byte_pos: FLD_RESET};
        end
      end
    end else if (wr_hit) begin
      win_ff[ch_idx][reg_idx] <= merge_write(win_ff[ch_idx][reg_idx], pwdata, pstrb);
    end
  end

  // ==========================================================================
  // apb answer: read data caught in the setup cycle, no wait states

  logic [DATA_W-1:0] prdata_ff;
  wire logic [DATA_W-1:0] nxt_prdata = (mapped && !pwrite) ? rd_word : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = access_p && !mapped;   // unmapped address answers error

  // ==========================================================================
  // per channel window views and ancillary detection

  logic [NCH-1:0] anc_active_ff;
  logic [NCH-1:0] nxt_anc_vec;   // per channel hit, gathered for one register

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign anc_cfg[c].bottom_hblank.pos  = win_ff[c][IDX_BH_POS];
    assign anc_cfg[c].bottom_hblank.size = win_ff[c][IDX_BH_SIZE];
    assign anc_cfg[c].top_vblank.pos     = win_ff[c][IDX_TV_POS];
    assign anc_cfg[c].top_vblank.size    = win_ff[c][IDX_TV_SIZE];
    assign anc_cfg[c].bottom_vblank.pos  = win_ff[c][IDX_BV_POS];
    assign anc_cfg[c].bottom_vblank.size = win_ff[c][IDX_BV_SIZE];

    // region select by field and blanking kind
    wire logic sel_bh = video_pos[c].valid && video_pos[c].bottom_field && video_pos[c].hblank;
    wire logic sel_tv = video_pos[c].valid && !video_pos[c].bottom_field && video_pos[c].vblank;
    wire logic sel_bv = video_pos[c].valid && video_pos[c].bottom_field && video_pos[c].vblank;

    // line counted from one, byte from zero
    wire logic hit_bh = sel_bh && in_window(video_pos[c], anc_cfg[c].bottom_hblank);
    wire logic hit_tv = sel_tv && in_window(video_pos[c], anc_cfg[c].top_vblank);
    wire logic hit_bv = sel_bv && in_window(video_pos[c], anc_cfg[c].bottom_vblank);
    assign nxt_anc_vec[c] = hit_bh || hit_tv || hit_bv;
  end

  // flag ancillary bytes one cycle later
  // one process owns the whole flag vector, so no bit has two writers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anc_active_ff <= '0;
    end else begin
      anc_active_ff <= nxt_anc_vec;
    end
  end

  assign anc_active = anc_active_ff;

endmodule

`default_nettype wire

// ### anc_window_chk.sv
// assertion checker for the ancillary window register bank
`default_nettype none
module anc_window_chk
  import anc_window_pkg::*;
#(parameter int NCH = 2) (
  input wire logic              pclk,            // clock
  input wire logic              presetn,         // reset
  input wire logic              psel,            // select
  input wire logic              penable,         // access
  input wire logic              pwrite,          // write
  input wire logic [ADDR_W-1:0] paddr,           // address
  input wire logic [DATA_W-1:0] pwdata,          // wdata
  input wire logic [STRB_W-1:0] pstrb,           // lanes
  input wire logic [DATA_W-1:0] prdata,          // rdata
  input wire logic              pready,          // ready
  input wire logic              pslverr,         // error
  input wire video_pos_t        video_pos [NCH], // scan
  input wire anc_cfg_t          anc_cfg [NCH],   // windows
  input wire logic [NCH-1:0]    anc_active       // flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [DATA_W-1:0] wd_ff;  // write data of the last edge
  logic [NCH-1:0]    hit;    // expected flag
  wire               acc = psel && penable;
  wire               map = paddr[1:0] == 0 && paddr[7:6] == 0 && paddr[4:2] < 6;
  // window test with 12-bit sums so no wrap
  function automatic logic in_w(anc_window_t w, video_pos_t v);
    return v.line_num >= w.pos.line && 12'(v.line_num) < w.pos.line + 12'(w.size.line)
      && v.byte_num >= w.pos.byte_pos && 12'(v.byte_num) < w.pos.byte_pos + 12'(w.size.byte_pos);
  endfunction
  function automatic logic hit_f(anc_cfg_t k, video_pos_t v);
    return v.valid && (v.bottom_field ? (v.hblank && in_w(k.bottom_hblank, v)) || (v.vblank && in_w(k.bottom_vblank, v))
      : v.vblank && in_w(k.top_vblank, v));
  endfunction
  // expected flag per channel
  for (genvar c = 0; c < NCH; c++) begin : g_hit
    assign hit[c] = hit_f(anc_cfg[c], video_pos[c]);
  end
  always_ff @(posedge pclk) wd_ff <= pwdata;
  chk_unmap_err: assert property (acc && !map |-> pslverr) else $error("no error on unmapped");
  chk_map_ok: assert property (acc && map |-> pready && !pslverr) else $error("mapped access refused");
  chk_rsvd_zero: assert property (acc && !pwrite |-> (prdata & 32'hf800_f800) == 0) else $error("gap bits set");
  chk_pos_write: assert property (acc && pwrite && paddr == OFF_BH_POS && pstrb == 4'hf
    |=> anc_cfg[0].bottom_hblank.pos == {wd_ff[26:16], wd_ff[10:0]}) else $error("position not stored");
  chk_size_write: assert property (acc && pwrite && paddr == CH_STRIDE + OFF_BV_SIZE && pstrb == 4'hf
    |=> anc_cfg[1].bottom_vblank.size == {wd_ff[26:16], wd_ff[10:0]}) else $error("size not stored");
  chk_hit_on: assert property (hit[0] |=> anc_active[0]) else $error("window byte not flagged");
  chk_hit_off: assert property (!hit[0] |=> !anc_active[0]) else $error("stray flag");
  chk_ch3_off: assert property (!hit[1] |=> !anc_active[1]) else $error("stray flag second channel");
endmodule
bind ancillary_window_config_regs anc_window_chk #(.NCH(NCH)) anc_window_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .video_pos, .anc_cfg, .anc_active);
`default_nettype wire

// ### video_sink_model.sv
// scan position source standing in for the video encoder side
`default_nettype none
module video_sink_model
  import anc_window_pkg::*;
#(parameter int NCH = 2) (
  input  wire logic           pclk,            // clock
  output video_pos_t          video_pos [NCH], // scan position
  input  wire logic [NCH-1:0] anc_active       // flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // idle: no valid position
  initial for (int i = 0; i < NCH; i++) video_pos[i] = '0;
  // one position for one cycle, then a changed invalid one; flag read a cycle on
  task automatic beat(input int c, input logic bf, hb, vb, input logic [FLD_W-1:0] ln, bn, output logic a);
    video_pos_t p;
    // lines counted from one, bytes from zero
    p = '{1'b1, bf, hb, vb, ln, bn};
    @(posedge pclk);
    video_pos[c] <= p;
    @(posedge pclk);
    video_pos[c] <= {1'b0, ~p[24:0]};
    @(negedge pclk);
    a = anc_active[c];
  endtask
endmodule
`default_nettype wire

// ### ancillary_window_config_regs_tb_top.sv
// self-checking bench for the ancillary window register bank
`default_nettype none
module ancillary_window_config_regs_tb_top import anc_window_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  video_pos_t  anc_start_line [2];
  anc_cfg_t    cfg [2];
  logic [1:0]  act;
  int          n_fail, tests_run, cyc;
  ancillary_window_config_regs #(.NCH(2)) ancillary_window_config_regs_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .video_pos(anc_start_line), .anc_cfg(cfg), .anc_active(act));
  video_sink_model video_sink_model_i (.pclk, .video_pos(anc_start_line), .anc_active(act));
  // clock and hang guard
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 0);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, 0, r, e);
    chk("read data", x, r);
    chk("read error", xe, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] r;
    logic e;
    apb(1, a, d, s, r, e);
    chk("write error", 0, e);
  endtask
  function automatic logic [7:0] ad(int k);
    return 8'(k / 6 * 32 + k % 6 * 4);
  endfunction
  // byte fields kept multiples of eight, gap bits set on purpose
  function automatic logic [31:0] pat(int k);
    return {5'h1f, 11'(12'h101 + k), 5'h1f, 11'(8 * k + 8)};
  endfunction
  task automatic bt(input int c, input logic bf, hb, vb, input logic [10:0] ln, bn, input logic x);
    logic a;
    video_sink_model_i.beat(c, bf, hb, vb, ln, bn, a);
    chk("anc active", x, a);
  endtask
  task automatic t_rw();
    for (int k = 0; k < 12; k++) rd(ad(k), 0);
    for (int k = 0; k < 12; k++) wr(ad(k), pat(k));
    for (int k = 0; k < 12; k++) rd(ad(k), pat(k) & 32'h07ff_07ff);
    chk("cfg", pat(11) & 32'h07ff_07ff,
        {5'b0, cfg[1].bottom_vblank.size.line, 5'b0, cfg[1].bottom_vblank.size.byte_pos});
  endtask
  task automatic t_err();
    rd(8'h41, 0, 1);
    rd(8'h18, 0, 1);
    wr(8'h00, '1, 4'h4);
    rd(8'h00, 32'h01ff_0008);
  endtask
  task automatic t_win();
    for (int k = 0; k < 6; k++) wr(ad(k), k[0] ? 32'h0003_0010 : 32'h0002_0008);
    bt(0, 1, 1, 0, 2, 8, 1);
    bt(0, 1, 1, 0, 4, 23, 1);
    bt(0, 1, 1, 0, 1, 8, 0);
    bt(0, 1, 1, 0, 5, 8, 0);
    bt(0, 1, 1, 0, 2, 24, 0);
    bt(0, 1, 1, 0, 2, 7, 0);
    bt(0, 0, 1, 0, 2, 8, 0);
    bt(0, 0, 0, 1, 3, 16, 1);
    bt(0, 1, 0, 1, 4, 8, 1);
    bt(1, 1, 1, 0, 2, 8, 0);
    bt(1, 1, 1, 0, 11'h107, 56, 1);
  endtask
  // reset, then the scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_rw();
    t_err();
    t_win();
    complete_run();
  end
endmodule
`default_nettype wire
